// file: common/cib_params.svh
// Purpose: named constants of the register slice
// Assumes: included by bare name from the design files
// Notes: one define per figure
`ifndef CIB_PARAMS_SVH
`define CIB_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CIB_OFS_INPUT_THR 8'h06
`define CIB_OFS_BSW_TMR 8'h07
`define CIB_OFS_STATUS 8'h08
`define CIB_OFS_REG_RST 8'h0B

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define CIB_RST_INPUT_THR 8'h46
`define CIB_RST_BSW_TMR 8'h4C
`define CIB_MSK_INPUT_THR 8'hCF
`define CIB_MSK_BSW_TMR 8'h6F
`define CIB_BIT_REG_RST 7

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CIB_OV_HI 7
`define CIB_OV_LO 6
`define CIB_VIN_HI 3
`define CIB_VIN_LO 0
`define CIB_BIT_TMR2X 6
`define CIB_BIT_BSW_DIS 5
`define CIB_BIT_BSW_DLY 3
`define CIB_BIT_BSW_RST_EN 2
`define CIB_TRK_HI 1
`define CIB_TRK_LO 0

// ----------------------------------------------------------------------------
// thresholds in millivolts
// ----------------------------------------------------------------------------
`define CIB_OV_MV_0 16'd5500
`define CIB_OV_MV_1 16'd6500
`define CIB_OV_MV_2 16'd10500
`define CIB_OV_MV_3 16'd14000
`define CIB_VIN_BASE_MV 16'd3900
`define CIB_VIN_STEP_MV 16'd100
`define CIB_TRK_MV_1 16'd200
`define CIB_TRK_MV_2 16'd250
`define CIB_TRK_MV_3 16'd300

// ----------------------------------------------------------------------------
// timing and bus
// ----------------------------------------------------------------------------
`define CIB_CLK_HZ 125000000
`define CIB_BSW_DLY_S 10
`define CIB_BSW_DLY_CYCLES (`CIB_BSW_DLY_S * `CIB_CLK_HZ)
`define CIB_BYTE_BITS 4'd8
// arbitrary bus address
`define CIB_DEV_ADDR_DEF 7'h2A

`endif

// file: common/cib_pkg.sv
// Purpose: shared types of the charger register slice
// Assumes: nothing
// Notes: constants live in cib_params.svh
package cib_pkg;

  typedef logic [15:0] cib_mv_t;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_WRITE,
    I2C_ACK,
    I2C_READ,
    I2C_RACK
  } cib_i2c_state_e;

endpackage

// file: hdl/cib_delay_timer.sv
// Purpose: fixed delay while run_i is held
// Assumes: run_i synchronous
// Notes: dropping run_i cancels and clears the count
`timescale 1ns/100ps
module cib_delay_timer
  import cib_pkg::*;
#(
  parameter int unsigned CYCLES = 1
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  output logic done_o
);

  localparam int unsigned W = (CYCLES < 2) ? 1 : $clog2(CYCLES);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("CYCLES below one");
  end

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (!run_i) begin
      nxt_cnt = '0;
      nxt_done = 1'b0;
    end else if (!done_ff) begin
      if (cnt_ff == W'(CYCLES - 1)) begin
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;

endmodule // cib_delay_timer

// file: hdl/cib_timer_pace.sv
// Purpose: passes or halves the safety-timer tick
// Assumes: tick_i is a one-cycle enable pulse
// Notes: output tick lags the input by one cycle
`timescale 1ns/100ps
module cib_timer_pace
  import cib_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // ticks
  input wire logic tick_i,
  input wire logic slow_i,
  output logic tick_o
);

  logic half_ff;
  logic nxt_half;
  logic tick_ff;
  logic nxt_tick;

  // every second tick passes while slowed
  always_comb begin
    nxt_half = half_ff;
    if (!slow_i) begin
      nxt_half = 1'b0;
    end else if (tick_i) begin
      nxt_half = ~half_ff;
    end
    nxt_tick = tick_i & (~slow_i | half_ff);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule // cib_timer_pace

// file: hdl/cib_charger_regs.sv
// Purpose: input threshold, battery-switch and status registers behind an I2C target
// Assumes: scl_i and sda_i are synchronous to sys_clk_i; sda is open drain
// Notes: decoded thresholds are given in millivolts
//
// Operation
// R1 - overvoltage code maps 5.5, 6.5, 10.5, 14 V; code 01 after reset
// R2 - input regulation threshold is 3.9 V plus 100 mV per code; 0110 after reset
// R3 - slowdown bit halves safety timer during input or thermal regulation; set at reset
// R4 - switch disable bit 1 turns battery switch off, 0 lets it on; clear at reset
// R5 - delay bit 0 turns off at once, 1 waits about 10 s
// R6 - switch reset-enable bit set at reset, restored by register reset and watchdog
// R7 - effective regulation threshold is higher of register and battery plus track offset; track code 00 uses the register value only
// R8 - status reports input source type: none, standard host port, adapter
// R9 - source-type field never carries the software input current limit
// R10 - status reports charge phase: idle, pre-charge, fast, termination
// R11 - thermal flag is one while thermal regulation is active
// R12 - system flag is one while battery below minimum and regulation active
// R13 - register-reset bit restores defaults, resets safety timer, then clears itself
// R14 - status and reserved bits ignore writes; reserved bits read zero
`timescale 1ns/100ps
`include "cib_params.svh"
module cib_charger_regs
  import cib_pkg::*;
#(
  // arbitrary target address
  parameter logic [6:0] DEV_ADDR = `CIB_DEV_ADDR_DEF,
  parameter int unsigned BSW_DLY_CYCLES = `CIB_BSW_DLY_CYCLES
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // charger state inputs
  input wire logic [2:0] input_source_type_i,
  input wire logic [1:0] charge_phase_i,
  input wire logic power_good_flag_i,
  input wire logic thermal_regulation_i,
  input wire logic battery_below_minimum_i,
  input wire logic system_minimum_regulation_i,
  input wire logic input_voltage_regulation_i,
  input wire logic input_current_regulation_i,
  input wire logic [15:0] battery_mv_i,
  // safety timer and watchdog
  input wire logic safety_tick_i,
  input wire logic watchdog_expired_i,
  output logic safety_tick_o,
  output logic safety_timer_reset_o,
  // decoded controls
  output logic [15:0] input_overvoltage_threshold_mv_o,
  output logic [15:0] input_voltage_regulation_threshold_mv_o,
  output logic [15:0] effective_regulation_threshold_mv_o,
  output logic battery_switch_on_o,
  output logic battery_switch_reset_enable_o
);

  if (BSW_DLY_CYCLES < 1) begin : g_bad_delay
    $error("BSW_DLY_CYCLES below one");
  end

  // --------------------------------------------------------------------------
  // decode functions
  // --------------------------------------------------------------------------
  function automatic cib_mv_t ov_mv(input logic [1:0] code);
    cib_mv_t v;
    v = `CIB_OV_MV_0;
    unique case (code)
      2'h0: v = `CIB_OV_MV_0;
      2'h1: v = `CIB_OV_MV_1;
      2'h2: v = `CIB_OV_MV_2;
      2'h3: v = `CIB_OV_MV_3;
    endcase
    return v;
  endfunction

  function automatic cib_mv_t vin_mv(input logic [3:0] code);
    return cib_mv_t'(`CIB_VIN_BASE_MV + `CIB_VIN_STEP_MV * {12'h000, code});
  endfunction

  function automatic cib_mv_t trk_mv(input logic [1:0] code);
    cib_mv_t v;
    v = 16'h0000;
    unique case (code)
      2'h0: v = 16'h0000;
      2'h1: v = `CIB_TRK_MV_1;
      2'h2: v = `CIB_TRK_MV_2;
      2'h3: v = `CIB_TRK_MV_3;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // pin edges
  // --------------------------------------------------------------------------
  logic scl_q_ff;
  logic sda_q_ff;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign bus_start = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign bus_stop = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // --------------------------------------------------------------------------
  // i2c target
  // --------------------------------------------------------------------------
  cib_i2c_state_e state_ff;
  cib_i2c_state_e nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic oe_ff;
  logic nxt_oe;
  logic rw_ff;
  logic nxt_rw;
  logic first_ff;
  logic nxt_first;
  logic nack_ff;
  logic nxt_nack;
  logic wr_en;
  logic [7:0] rd_data_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_oe = oe_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_nack = nack_ff;
    wr_en = 1'b0;
    if (bus_start) begin
      nxt_state = I2C_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = I2C_IDLE;
      nxt_oe = 1'b0;
    end else begin
      unique case (state_ff)
        I2C_IDLE: begin
        end
        I2C_ADDR, I2C_WRITE: begin
          if (scl_rise && cnt_ff != `CIB_BYTE_BITS) begin
            nxt_shift = {shift_ff[6:0], sda_i};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `CIB_BYTE_BITS) begin
            if (state_ff == I2C_ADDR) begin
              if (shift_ff[7:1] == DEV_ADDR) begin
                nxt_state = I2C_ACK;
                nxt_oe = 1'b1;
                nxt_rw = shift_ff[0];
                nxt_first = ~shift_ff[0];
              end else begin
                nxt_state = I2C_IDLE;
              end
            end else begin
              nxt_state = I2C_ACK;
              nxt_oe = 1'b1;
              if (first_ff) begin
                nxt_ptr = shift_ff;
                nxt_first = 1'b0;
              end else begin
                wr_en = 1'b1;
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_shift = rd_data_ff;
              nxt_oe = ~rd_data_ff[7];
              nxt_cnt = 4'h1;
              nxt_state = I2C_READ;
            end else begin
              nxt_oe = 1'b0;
              nxt_cnt = 4'h0;
              nxt_state = I2C_WRITE;
            end
          end
        end
        I2C_READ: begin
          if (scl_fall) begin
            if (cnt_ff != `CIB_BYTE_BITS) begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe = ~shift_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end else begin
              nxt_oe = 1'b0;
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = I2C_RACK;
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            nxt_nack = sda_i;
          end else if (scl_fall) begin
            if (nack_ff) begin
              nxt_state = I2C_IDLE;
            end else begin
              nxt_shift = rd_data_ff;
              nxt_oe = ~rd_data_ff[7];
              nxt_cnt = 4'h1;
              nxt_state = I2C_READ;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= I2C_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      oe_ff <= nxt_oe;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      nack_ff <= nxt_nack;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_ff;

  // --------------------------------------------------------------------------
  // register bank
  // --------------------------------------------------------------------------
  logic [7:0] thr_ff;
  logic [7:0] nxt_thr;
  logic [7:0] bsw_ff;
  logic [7:0] nxt_bsw;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic reg_rst_ff;
  logic nxt_reg_rst;
  logic tmr_rst_ff;
  logic [7:0] nxt_rd_data;

  always_comb begin
    nxt_thr = thr_ff;
    nxt_bsw = bsw_ff;
    nxt_reg_rst = reg_rst_ff;
    if (reg_rst_ff) begin
      // R13 defaults then self-clear
      nxt_thr = `CIB_RST_INPUT_THR;
      nxt_bsw = `CIB_RST_BSW_TMR;
      nxt_reg_rst = 1'b0;
    end else begin
      if (wr_en) begin
        // R14 masked writes only
        unique case (ptr_ff)
          `CIB_OFS_INPUT_THR: nxt_thr = shift_ff & `CIB_MSK_INPUT_THR;
          `CIB_OFS_BSW_TMR: nxt_bsw = shift_ff & `CIB_MSK_BSW_TMR;
          `CIB_OFS_REG_RST: nxt_reg_rst = shift_ff[`CIB_BIT_REG_RST];
          default: begin
          end
        endcase
      end
      if (watchdog_expired_i) begin
        // R6 watchdog restores bits
        nxt_bsw[`CIB_BIT_TMR2X] = 1'b1;
        nxt_bsw[`CIB_BIT_BSW_RST_EN] = 1'b1;
      end
    end
    // R8 source type as reported
    // R9 no current limit here
    // R10 charge phase field
    // R11 thermal flag
    // R12 system minimum flag
    nxt_stat = {input_source_type_i, charge_phase_i, power_good_flag_i, thermal_regulation_i,
                battery_below_minimum_i & system_minimum_regulation_i};
    // R14 reserved reads zero
    unique case (ptr_ff)
      `CIB_OFS_INPUT_THR: nxt_rd_data = thr_ff;
      `CIB_OFS_BSW_TMR: nxt_rd_data = bsw_ff;
      `CIB_OFS_STATUS: nxt_rd_data = stat_ff;
      `CIB_OFS_REG_RST: nxt_rd_data = {reg_rst_ff, 7'h00};
      default: nxt_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // R1 overvoltage code 01
      // R2 regulation code 0110
      thr_ff <= `CIB_RST_INPUT_THR;
      // R3 R4 R5 R6 power-on values
      bsw_ff <= `CIB_RST_BSW_TMR;
      stat_ff <= 8'h00;
      reg_rst_ff <= 1'b0;
      tmr_rst_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      thr_ff <= nxt_thr;
      bsw_ff <= nxt_bsw;
      stat_ff <= nxt_stat;
      reg_rst_ff <= nxt_reg_rst;
      // R13 safety timer reset pulse
      tmr_rst_ff <= reg_rst_ff;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign safety_timer_reset_o = tmr_rst_ff;

  // --------------------------------------------------------------------------
  // decoded thresholds
  // --------------------------------------------------------------------------
  cib_mv_t ov_ff;
  cib_mv_t vin_ff;
  cib_mv_t eff_ff;
  cib_mv_t nxt_ov;
  cib_mv_t nxt_vin;
  cib_mv_t nxt_eff;
  cib_mv_t trk_sum;

  always_comb begin
    // R1 overvoltage decode
    nxt_ov = ov_mv(thr_ff[`CIB_OV_HI:`CIB_OV_LO]);
    // R2 regulation decode
    nxt_vin = vin_mv(thr_ff[`CIB_VIN_HI:`CIB_VIN_LO]);
    // R7 higher of both, register only when track code is 00
    trk_sum = cib_mv_t'(battery_mv_i + trk_mv(bsw_ff[`CIB_TRK_HI:`CIB_TRK_LO]));
    nxt_eff = nxt_vin;
    if (bsw_ff[`CIB_TRK_HI:`CIB_TRK_LO] != 2'h0 && trk_sum > nxt_vin) begin
      nxt_eff = trk_sum;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ov_ff <= 16'h0000;
      vin_ff <= 16'h0000;
      eff_ff <= 16'h0000;
    end else begin
      ov_ff <= nxt_ov;
      vin_ff <= nxt_vin;
      eff_ff <= nxt_eff;
    end
  end

  assign input_overvoltage_threshold_mv_o = ov_ff;
  assign input_voltage_regulation_threshold_mv_o = vin_ff;
  assign effective_regulation_threshold_mv_o = eff_ff;

  // --------------------------------------------------------------------------
  // battery switch and safety timer pace
  // --------------------------------------------------------------------------
  logic dly_done;
  logic bsw_on_ff;
  logic nxt_bsw_on;
  logic slow_timer;

  cib_delay_timer #(
    .CYCLES(BSW_DLY_CYCLES)
  ) u_bsw_delay (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(bsw_ff[`CIB_BIT_BSW_DIS] & bsw_ff[`CIB_BIT_BSW_DLY]),
    .done_o(dly_done)
  );

  always_comb begin
    // R4 disable turns switch off
    // R5 immediate or delayed
    nxt_bsw_on = ~(bsw_ff[`CIB_BIT_BSW_DIS] & (~bsw_ff[`CIB_BIT_BSW_DLY] | dly_done));
    // R3 slowdown condition
    slow_timer = bsw_ff[`CIB_BIT_TMR2X] &
                 (input_voltage_regulation_i | input_current_regulation_i | thermal_regulation_i);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bsw_on_ff <= 1'b1;
    end else begin
      bsw_on_ff <= nxt_bsw_on;
    end
  end

  cib_timer_pace u_pace (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(safety_tick_i),
    .slow_i(slow_timer),
    .tick_o(safety_tick_o)
  );

  assign battery_switch_on_o = bsw_on_ff;
  assign battery_switch_reset_enable_o = bsw_ff[`CIB_BIT_BSW_RST_EN];

endmodule // cib_charger_regs

// file: tb/cib_asserts.sv
// Purpose: port checks
// Assumes: one clock domain
// Notes: thresholds checked one edge after reset
`timescale 1ns/100ps
module cib_asserts
  import cib_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // bus and charger inputs
  input wire logic scl_i,
  input wire logic thermal_regulation_i,
  input wire logic input_voltage_regulation_i,
  input wire logic input_current_regulation_i,
  input wire logic safety_tick_i,
  input wire logic watchdog_expired_i,
  // design outputs
  input wire logic sda_oe_o,
  input wire logic safety_tick_o,
  input wire logic safety_timer_reset_o,
  input wire logic [15:0] input_overvoltage_threshold_mv_o,
  input wire logic [15:0] input_voltage_regulation_threshold_mv_o,
  input wire logic [15:0] effective_regulation_threshold_mv_o,
  input wire logic battery_switch_reset_enable_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  sequence s_plain_tick;
    safety_tick_i && !(thermal_regulation_i || input_voltage_regulation_i || input_current_regulation_i);
  endsequence

  a_tick_passes: assert property (s_plain_tick |=> safety_tick_o)
    else $error("tick lost");
  a_tick_no_spur: assert property (!safety_tick_i |=> !safety_tick_o)
    else $error("spurious tick");
  a_ovp_decode: assert property ($past(rst_n_i) |-> input_overvoltage_threshold_mv_o inside
    {16'h157C, 16'h1964, 16'h2904, 16'h36B0}) else $error("bad overvoltage");
  a_vin_step: assert property ($past(rst_n_i) |-> input_voltage_regulation_threshold_mv_o >= 16'h0F3C &&
    input_voltage_regulation_threshold_mv_o <= 16'h1518 &&
    (input_voltage_regulation_threshold_mv_o - 16'h0F3C) % 16'h0064 == 16'h0000)
    else $error("bad regulation step");
  a_eff_floor: assert property ($past(rst_n_i) && $stable(input_voltage_regulation_threshold_mv_o) |->
    effective_regulation_threshold_mv_o >= input_voltage_regulation_threshold_mv_o)
    else $error("effective below register");
  a_wdog_rst_en: assert property (watchdog_expired_i |=> battery_switch_reset_enable_o)
    else $error("reset enable not restored");
  a_timer_rst_once: assert property (safety_timer_reset_o |=> !safety_timer_reset_o)
    else $error("reset pulse long");
  a_oe_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("sda moved, scl high");
endmodule // cib_asserts

// file: tb/cib_i2c_host.sv
// Purpose: two-wire bus host
// Assumes: sda_i is the resolved line
// Notes: scl high between frames
`timescale 1ns/100ps
module cib_i2c_host
  import cib_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // bus lines, sda_o high releases
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  logic busy = 1'b0;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // bus primitives
  // ----------------------------------------------------------------------------
  task automatic step(input logic c, input logic d, input int n);
    @(posedge sys_clk_i);
    scl_o <= c;
    sda_o <= d;
    repeat (n - 1) @(posedge sys_clk_i);
  endtask

  // data moves mid low phase
  task automatic bit_x(input logic b, output logic r);
    step(1'b0, sda_o, 2);
    step(1'b0, b, 2);
    step(1'b1, b, 4);
    r = sda_i;
  endtask

  task automatic start();
    if (busy) begin
      step(1'b0, sda_o, 2);
      step(1'b0, 1'b1, 2);
      step(1'b1, 1'b1, 4);
    end
    step(1'b1, 1'b0, 4);
    busy = 1'b1;
  endtask

  task automatic stop();
    step(1'b0, sda_o, 2);
    step(1'b0, 1'b0, 2);
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 4);
    busy = 1'b0;
  endtask

  task automatic byte_tx(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, nack);
  endtask

  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d, output logic nk);
    logic n0, n1, n2;
    start();
    byte_tx({a, 1'b0}, n0);
    byte_tx(ofs, n1);
    byte_tx(d, n2);
    stop();
    nk = n0 | n1 | n2;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d, output logic nk);
    logic n0, n1, n2;
    start();
    byte_tx({a, 1'b0}, n0);
    byte_tx(ofs, n1);
    start();
    byte_tx({a, 1'b1}, n2);
    byte_rx(1'b1, d);
    stop();
    nk = n0 | n1 | n2;
  endtask
endmodule // cib_i2c_host

// file: tb/cib_charger_regs_bench.sv
// Purpose: self-checking bench
// Assumes: host model owns the bus
// Notes: switch-off delay shortened to DLY cycles
`timescale 1ns/100ps
module cib_charger_regs_bench;
  import cib_pkg::*;
  localparam int unsigned DLY = 200;
  // arbitrary target address
  localparam logic [6:0] ADDR = 7'h2A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda, dsda, doe, hsda, tick_o, trst, sw_on, rst_en, nk;
  logic [2:0] src = 3'h0;
  logic [1:0] phase = 2'h0;
  logic pg = 1'b0, therm = 1'b0, below = 1'b0, sysmin = 1'b0, vreg = 1'b0, ireg = 1'b0;
  logic tick = 1'b0, wdog = 1'b0;
  logic [15:0] bat = 16'h0FA0;
  logic [15:0] ov, vin, eff;
  logic [7:0] rv;
  int failures = 0, total_checks = 0, ticks = 0, trsts = 0;

  always #4 clk = ~clk;
  assign sda = hsda & (doe ? dsda : 1'b1);
  always @(posedge clk) begin
    if (tick_o === 1'b1) ticks <= ticks + 1;
    if (trst === 1'b1) trsts <= trsts + 1;
  end

  cib_charger_regs #(.DEV_ADDR(ADDR), .BSW_DLY_CYCLES(DLY)) u_cib_charger_regs (
    .sys_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(dsda), .sda_oe_o(doe),
    .input_source_type_i(src), .charge_phase_i(phase), .power_good_flag_i(pg), .thermal_regulation_i(therm),
    .battery_below_minimum_i(below), .system_minimum_regulation_i(sysmin), .input_voltage_regulation_i(vreg),
    .input_current_regulation_i(ireg), .battery_mv_i(bat), .safety_tick_i(tick), .watchdog_expired_i(wdog),
    .safety_tick_o(tick_o), .safety_timer_reset_o(trst), .input_overvoltage_threshold_mv_o(ov),
    .input_voltage_regulation_threshold_mv_o(vin), .effective_regulation_threshold_mv_o(eff),
    .battery_switch_on_o(sw_on), .battery_switch_reset_enable_o(rst_en));
  cib_i2c_host u_cib_i2c_host (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    u_cib_i2c_host.wr(ADDR, ofs, d, nk);
    chk(16'(nk), 16'h0);
  endtask
  task automatic sw(input logic e);
    chk(16'(sw_on), 16'(e));
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    u_cib_i2c_host.rd(ADDR, ofs, rv, nk);
    chk({nk, 7'h00, rv}, {8'h00, exp});
  endtask
  task automatic pulses(input int exp);
    int t0;
    t0 = ticks;
    repeat (8) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    chk(16'(ticks - t0), 16'(exp));
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    chk(ov, 16'h1964);
    chk(vin, 16'h1194);
    chk(eff, 16'h1194);
    sw(1'b1);
    chk(16'(rst_en), 16'h1);
    rd(8'h06, 8'h46);
    rd(8'h07, 8'h4C);
  endtask
  task automatic t_thr();
    logic [15:0] tab [4] = '{16'h157C, 16'h1964, 16'h2904, 16'h36B0};
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, {i[1:0], 2'b11, 4'(i * 5)});
      chk(ov, tab[i]);
      chk(vin, 16'h0F3C + 16'h0064 * 16'(i * 5));
      rd(8'h06, {i[1:0], 2'b00, 4'(i * 5)});
    end
    wr(8'h06, 8'h46);
  endtask
  task automatic t_track();
    logic [15:0] off [4] = '{16'h0000, 16'h00C8, 16'h00FA, 16'h012C};
    @(posedge clk) bat <= 16'h1130;
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, {6'h13, i[1:0]});
      chk(eff, (i == 0) ? 16'h1194 : 16'h1130 + off[i]);
    end
    @(posedge clk) bat <= 16'h0FA0;
    repeat (3) @(posedge clk);
    chk(eff, 16'h1194);
    wr(8'h07, 8'h4C);
  endtask
  task automatic t_switch();
    wr(8'h07, 8'h20);
    sw(1'b0);
    wr(8'h07, 8'h08);
    sw(1'b1);
    wr(8'h07, 8'h28);
    sw(1'b1);
    repeat (DLY) @(posedge clk);
    sw(1'b0);
    wr(8'h07, 8'h4C);
    sw(1'b1);
  endtask
  task automatic t_status();
    wr(8'h08, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src <= (i == 3) ? 3'h7 : 3'(i);
      phase <= 2'(i);
      pg <= i[0];
      therm <= i[1];
      below <= i[1];
      sysmin <= i[0];
      rd(8'h08, {(i == 3) ? 3'h7 : 3'(i), 2'(i), i[0], i[1], i[0] & i[1]});
    end
    rd(8'h0C, 8'h00);
  endtask
  task automatic t_tick();
    @(posedge clk) therm <= 1'b0;
    pulses(8);
    @(posedge clk) therm <= 1'b1;
    pulses(4);
    wr(8'h07, 8'h0C);
    pulses(8);
    wr(8'h07, 8'h4C);
    @(posedge clk) therm <= 1'b0;
    vreg <= 1'b1;
    pulses(4);
    @(posedge clk) vreg <= 1'b0;
    ireg <= 1'b1;
    pulses(4);
    @(posedge clk) ireg <= 1'b0;
  endtask
  task automatic t_rst();
    int t0;
    wr(8'h07, 8'h00);
    chk(16'(rst_en), 16'h0);
    @(posedge clk) wdog <= 1'b1;
    @(posedge clk) wdog <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(rst_en), 16'h1);
    rd(8'h07, 8'h44);
    wr(8'h06, 8'h8F);
    t0 = trsts;
    wr(8'h0B, 8'h80);
    chk(16'(trsts - t0), 16'h1);
    rd(8'h06, 8'h46);
    rd(8'h07, 8'h4C);
    rd(8'h0B, 8'h00);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_thr();
    t_track();
    t_switch();
    t_status();
    t_tick();
    t_rst();
    report_and_stop();
  end
endmodule // cib_charger_regs_bench

bind cib_charger_regs cib_asserts u_cib_asserts (.*);
